// File: verification/aal_datapath_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module add_and_logic_ops_tb_top;
    logic                core_clk;
    logic                rst_n;
    logic                op_valid;
    logic                mem_we;
    logic                exp_we;
    aal_pkg::aal_op_t    op;
    aal_pkg::aal_flags_t flags;
    aal_pkg::aal_flags_t exp_f;
    logic [7:0]          mem_addr, mem_rdata, imm, working_register, mem_waddr, mem_wdata;
    logic [7:0]          exp_w, exp_d, exp_a, r;
    logic [8:0]          sum;
    int                  n_errors, cmp_count, seed, i;
    aal_pkg::aal_op_t    ops [6];
    aal_datapath dut (.core_clk(core_clk), .rst_n(rst_n), .op_valid(op_valid), .op(op),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .imm(imm), .working_register(working_register),
        .flags(flags), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata));
    task end_sim;
        if (n_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // inputs change at the edge; check lands 1 ns later, after the edge's updates
    task drive(input logic v, input aal_pkg::aal_op_t o, input logic [7:0] a, d, x);
        @(posedge core_clk);
        op_valid <= v; op <= o; mem_addr <= a; mem_rdata <= d; imm <= x;
        #1;
        `CHK(working_register, exp_w)
        `CHK(flags, exp_f)
        `CHK(mem_we, exp_we)
        if (exp_we)
        begin
            `CHK(mem_waddr, exp_a)
            `CHK(mem_wdata, exp_d)
        end
        exp_we = 1'b0;
        if (v)
        begin
            case (o)
                aal_pkg::AAL_ADD:
                begin
                    sum = {1'b0, exp_w} + {1'b0, d};
                    exp_d = sum[7:0]; exp_a = a; exp_we = 1'b1;
                    exp_f = '{(exp_w[7] == d[7]) && (sum[7] != d[7]), sum[7:0] == 8'h00,
                        ({1'b0, exp_w[3:0]} + {1'b0, d[3:0]}) >= 5'h10, sum[8]};
                end
                aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC, aal_pkg::AAL_ANDI:
                begin
                    r = exp_w & ((o == aal_pkg::AAL_ANDI) ? x : d);
                    exp_w = r; exp_f.zero_flag = (r == 8'h00);
                end
                aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM:
                begin
                    exp_d = d & exp_w; exp_a = a; exp_we = 1'b1;
                end
                default: ;
            endcase
        end
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial
    begin
        #100000;
        n_errors++;
        end_sim;
    end
    initial
    begin
        rst_n = 1'b0; op_valid = 1'b0; op = aal_pkg::AAL_NOP; mem_addr = 8'h00;
        mem_rdata = 8'h00; imm = 8'h00; seed = 67;
        exp_w = 8'h00; exp_f = aal_pkg::FLAGS_RST; exp_we = 1'b0; exp_d = 8'h00; exp_a = 8'h00;
        ops = '{aal_pkg::AAL_NOP, aal_pkg::AAL_ADD, aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC, aal_pkg::AAL_ANDI,
            aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM, aal_pkg::aal_op_t'(5'h03)};
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        drive(1'b1, aal_pkg::AAL_ADD, 8'h10, 8'hFC, 8'h00);
        drive(1'b1, aal_pkg::AAL_ADD, 8'hFF, 8'h00, 8'h00);
        drive(1'b1, aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM, 8'h20, 8'hFF, 8'h00);
        drive(1'b0, aal_pkg::AAL_ADD, 8'h30, 8'h7F, 8'h00);
        for (i = 0; i < 300; i++)
            drive(($random(seed) % 4) != 0, ops[$unsigned($random(seed)) % 6], 8'($random(seed)),
                8'($random(seed)), 8'($random(seed)));
        // reset in mid-run: the pending op is dropped, outputs return to reset values
        rst_n <= 1'b0;
        exp_w = aal_pkg::WREG_RST; exp_f = aal_pkg::FLAGS_RST; exp_we = 1'b0;
        drive(1'b0, aal_pkg::AAL_ADD, 8'h11, 8'hFF, 8'h00);
        drive(1'b0, aal_pkg::AAL_ADD, 8'h12, 8'hFF, 8'h00);
        rst_n <= 1'b1;
        drive(1'b1, aal_pkg::AAL_ADD, 8'h40, 8'h81, 8'h00);
        drive(1'b1, aal_pkg::AAL_ANDI, 8'h00, 8'h00, 8'h0F);
        drive(1'b0, aal_pkg::AAL_NOP, 8'h00, 8'h00, 8'h00);
        end_sim;
    end
endmodule

// File: verilog/aal_datapath.sv
`timescale 1ns/1ps
// executes one operation per cycle when op_valid is high.
// memory is external: the operand arrives on mem_rdata in the same cycle as the
// opcode, and the result leaves as a registered write one cycle later.
module aal_datapath
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        op_valid,
    input  wire aal_pkg::aal_op_t            op,
    input  wire logic [aal_pkg::DATA_W-1:0]  mem_addr,
    input  wire logic [aal_pkg::DATA_W-1:0]  mem_rdata,
    input  wire logic [aal_pkg::DATA_W-1:0]  imm,
    output logic [aal_pkg::DATA_W-1:0]       working_register,
    output aal_pkg::aal_flags_t              flags,
    output logic                             mem_we,
    output logic [aal_pkg::DATA_W-1:0]       mem_waddr,
    output logic [aal_pkg::DATA_W-1:0]       mem_wdata
);
    localparam int W = aal_pkg::DATA_W;

    logic [W:0]   sum_full;
    logic [4:0]   sum_low;
    logic [W-1:0] and_mem;
    logic [W-1:0] and_imm;

    // half carry taken from a separate nibble add rather than sum bits
    assign sum_full = {1'b0, working_register} + {1'b0, mem_rdata};
    assign sum_low  = {1'b0, working_register[3:0]} + {1'b0, mem_rdata[3:0]};
    assign and_mem  = working_register & mem_rdata;
    assign and_imm  = working_register & imm;

    // working register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            working_register <= aal_pkg::WREG_RST;
        else if (op_valid && op == aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC)
            working_register <= and_mem;
        else if (op_valid && op == aal_pkg::AAL_ANDI)
            working_register <= and_imm;
    end

    // status flags
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            flags <= aal_pkg::FLAGS_RST;
        else if (op_valid)
        begin
            case (op)
                aal_pkg::AAL_ADD:
                begin
                    flags.carry_flag      <= sum_full[W];
                    flags.half_carry_flag <= sum_low[4];
                    flags.zero_flag       <= (sum_full[W-1:0] == '0);
                    flags.signed_wrap_flag <= (working_register[W-1] == mem_rdata[W-1])
                        && (sum_full[W-1] != mem_rdata[W-1]);
                end
                aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC: flags.zero_flag <= (and_mem == '0);
                aal_pkg::AAL_ANDI:     flags.zero_flag <= (and_imm == '0);
                // and into memory leaves every flag as it was
                default: ;
            endcase
        end
    end

    // memory write port
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mem_we    <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= '0;
        end
        else
        begin
            mem_we    <= op_valid && (op == aal_pkg::AAL_ADD || op == aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM);
            mem_waddr <= mem_addr;
            if (op == aal_pkg::AAL_ADD)
                mem_wdata <= sum_full[W-1:0];
            else
                mem_wdata <= and_mem;
        end
    end

    // checks restate the rules from the operands; the zero-flag terms of AST_ADD_CARRY, AST_ANDI and the ACC check read mem_wdata or working_register
    AST_ADD_WRITE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_ADD
        |=> mem_we
        && mem_wdata == 8'($past(working_register) + $past(mem_rdata))
        && mem_waddr == $past(mem_addr))
        else $error("add result not written back");

    AST_ADD_CARRY: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_ADD
        |=> flags.carry_flag == ({1'b0, $past(working_register)}
            + {1'b0, $past(mem_rdata)} > 9'h0FF)
        && flags.zero_flag == (mem_wdata == 8'h00))
        else $error("add carry or zero wrong");

    AST_ADD_HALF: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_ADD
        |=> flags.half_carry_flag == ({1'b0, $past(working_register[3:0])}
            + {1'b0, $past(mem_rdata[3:0])} > 5'h0F))
        else $error("half carry wrong");

    AST_ADD_WRAP: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_ADD
        |=> flags.signed_wrap_flag ==
        ($signed($past(working_register)) + $signed($past(mem_rdata)) > 127
        || $signed($past(working_register)) + $signed($past(mem_rdata)) < -128))
        else $error("overflow flag wrong");

    AST_ADD_ZERO: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_ADD
        |=> flags.zero_flag == (8'($past(working_register) + $past(mem_rdata)) == 8'h00))
        else $error("add zero flag wrong");

    AST_ADD_KEEPS_WREG: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_ADD
        |=> $stable(working_register))
        else $error("add changed working register");

    AST_AND_INTO_MEMORY_OP_ACC: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC
        |=> working_register == ($past(working_register) & $past(mem_rdata))
        && !mem_we
        && flags.zero_flag == (working_register == 8'h00)
        && $stable(flags.carry_flag)
        && $stable(flags.half_carry_flag)
        && $stable(flags.signed_wrap_flag))
        else $error("and into register wrong");

    AST_ANDI: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_ANDI
        |=> working_register == ($past(working_register) & $past(imm))
        && !mem_we
        && flags.zero_flag == (working_register == 8'h00)
        && $stable(flags.carry_flag)
        && $stable(flags.half_carry_flag)
        && $stable(flags.signed_wrap_flag))
        else $error("and immediate wrong");

    AST_AND_INTO_MEMORY_OP_MEM: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && op == aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM
        |=> mem_we
        && mem_wdata == ($past(working_register) & $past(mem_rdata))
        && mem_waddr == $past(mem_addr)
        && $stable(working_register)
        && $stable(flags))
        else $error("and into memory wrong");

    // one bitwise check per data bit
    for (genvar b = 0; b < W; b++)
    begin : g_and_bit
        AST_AND_BIT: assert property (
            @(posedge core_clk) disable iff (!rst_n)
            op_valid && op == aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM
            |=> mem_wdata[b] == ($past(working_register[b]) & $past(mem_rdata[b])))
            else $error("and into memory bit wrong");
    end

    AST_IDLE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !op_valid
        |=> !mem_we
        && $stable(working_register)
        && $stable(flags))
        else $error("state changed while idle");

    // a corrupt opcode must behave as a no-operation, never as a write
    AST_BAD_OP: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        op_valid && !(op inside {aal_pkg::AAL_ADD, aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC,
            aal_pkg::AAL_ANDI, aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM})
        |=> !mem_we
        && $stable(working_register)
        && $stable(flags))
        else $error("unknown opcode changed state");

    AST_WE_PULSE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mem_we
        |-> $past(op_valid)
        && ($past(op) == aal_pkg::AAL_ADD || $past(op) == aal_pkg::AAL_AND_INTO_MEMORY_OP_MEM))
        else $error("memory write without a writing op");

    AST_WREG_SOURCE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $changed(working_register)
        |-> $past(op_valid)
        && ($past(op) == aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC || $past(op) == aal_pkg::AAL_ANDI))
        else $error("working register changed by wrong op");

    AST_FLAGS_SOURCE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $changed(flags)
        |-> $past(op_valid)
        && ($past(op) inside {aal_pkg::AAL_ADD, aal_pkg::AAL_AND_INTO_MEMORY_OP_ACC, aal_pkg::AAL_ANDI}))
        else $error("flags changed by wrong op");

    // no disable here: the reset values themselves are what is checked
    AST_RESET_VALUES: assert property (
        @(posedge core_clk)
        !rst_n
        |=> working_register == aal_pkg::WREG_RST
        && flags == aal_pkg::FLAGS_RST
        && !mem_we
        && mem_waddr == 8'h00
        && mem_wdata == 8'h00)
        else $error("reset values wrong");
endmodule

// File: verilog/aal_pkg.sv
package aal_pkg;
    localparam int DATA_W = 8;

    typedef enum logic [4:0] {
        AAL_NOP = 5'h01,
        AAL_ADD = 5'h02,
        AAL_AND_INTO_MEMORY_OP_ACC = 5'h04,
        AAL_ANDI = 5'h08,
        AAL_AND_INTO_MEMORY_OP_MEM = 5'h10
    } aal_op_t;

    typedef struct packed {
        logic signed_wrap_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
    } aal_flags_t;

    localparam logic [DATA_W-1:0] WREG_RST = 8'h00;
    localparam aal_flags_t FLAGS_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
endpackage
